/* File: src/icc_control.sv */
// Operation
// - Port enable set: the block takes over the clock and data pins.
// - Port enable clear: block inactive, pins go back to ordinary port control.
// - Halt-in-idle set: block stops during device idle; clear: keeps running.
// - As client, clock held low while release bit is 0, freed while 1.
// - With stretching enabled software may write release as 0 or 1.
// - Release bit cleared by hardware at start of every client data byte sent.
// - Release bit cleared by hardware at end of every matched client address byte.
// - Release cleared at end of received data byte only when stretching enabled.
// - With stretching disabled, software writes can only set release to 1.
// - Accept-all mode acknowledges every address without comparison.
// - Software keeps accept-all at 0 during host operation.
// - Address-width bit picks a 10-bit or 7-bit own client address.
// - Slew-disable bit turns pin slew-rate control off.
// - Bus-level bit selects system management bus input thresholds.
// - Stretch-enable allows software and receive clock stretching in client mode.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module icc_control
  import icc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic pins_owned,
  output logic slew_control_off,
  output logic smbus_threshold_select
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wr,
                                          input logic [1:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wr[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wr[15:8];
    end
    return res;
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    return (a == ICC_OFS_CTRL) || (a == ICC_OFS_OWN) || (a == ICC_OFS_STAT) ||
           (a == ICC_OFS_DATA);
  endfunction

  icc_state_t s_r;
  icc_state_t s_nxt;

  logic port_enable;
  logic stretch_enable;
  logic run;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic acc;
  logic wr_acc;
  logic rd_data;
  logic clk_hold;
  logic [15:0] ctrl_wr;

  assign port_enable = s_r.ctrl[ICC_B_PORT_ENABLE];
  assign stretch_enable = s_r.ctrl[ICC_B_STRETCH_EN];
  // Engine runs only when enabled and not parked by idle.
  assign run = port_enable && !(s_r.ctrl[ICC_B_HALT_IN_IDLE] && cpu_idle);
  assign scl_rise = s_r.sy2.scl && !s_r.prev.scl;
  assign scl_fall = !s_r.sy2.scl && s_r.prev.scl;
  assign start_seen = s_r.sy2.scl && s_r.prev.scl && !s_r.sy2.sda && s_r.prev.sda;
  assign stop_seen = s_r.sy2.scl && s_r.prev.scl && s_r.sy2.sda && !s_r.prev.sda;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  assign acc = psel && penable && clk_en;
  assign wr_acc = acc && pwrite && is_reg(paddr);
  assign rd_data = acc && !pwrite && (paddr == ICC_OFS_DATA);
  assign pready = clk_en;
  assign pslverr = psel && penable && !is_reg(paddr);

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        ICC_OFS_CTRL: prdata = {16'h0000, s_r.ctrl & ICC_CTRL_MASK};
        ICC_OFS_OWN: prdata = {22'h00_0000, s_r.own};
        ICC_OFS_STAT: begin
          prdata[ICC_S_RX_FULL] = s_r.rx_full;
          prdata[ICC_S_ADDRESSED] = s_r.addressed;
          prdata[ICC_S_READ_DIR] = s_r.read_dir;
          prdata[ICC_S_TEN_HIT] = s_r.ten_hit;
          prdata[ICC_S_CLK_HELD] = clk_hold;
        end
        ICC_OFS_DATA: prdata = {24'h00_0000, s_r.rx_byte};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------------------
  // Stretch only once the clock is already low so a high phase is never cut.
  assign clk_hold = run && s_r.addressed && !s_r.ctrl[ICC_B_CLOCK_RELEASE] &&
                    !s_r.sy2.scl;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = clk_hold;
  assign sda_oe = run && s_r.sda_drive;
  assign pins_owned = port_enable;
  assign slew_control_off = s_r.ctrl[ICC_B_SLEW_OFF];
  assign smbus_threshold_select = s_r.ctrl[ICC_B_SMBUS];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic hit;
    logic to_tx;
    logic [7:0] b;
    logic [15:0] own_wr;
    hit = 1'b0;
    own_wr = 16'h0000;
    to_tx = 1'b0;
    b = s_r.shift;
    s_nxt = s_r;
    ctrl_wr = 16'h0000;
    s_nxt.sy1 = '{scl: scl_i, sda: sda_i};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.prev = s_r.sy2;

    if (!port_enable) begin
      s_nxt.phase = ICC_PH_IDLE;
      s_nxt.addressed = 1'b0;
      s_nxt.ten_hit = 1'b0;
      s_nxt.sda_drive = 1'b0;
      s_nxt.bits = 4'h0;
    end else if (run) begin
      if (stop_seen) begin
        s_nxt.phase = ICC_PH_IDLE;
        s_nxt.addressed = 1'b0;
        s_nxt.ten_hit = 1'b0;
        s_nxt.sda_drive = 1'b0;
      end else if (start_seen) begin
        s_nxt.phase = ICC_PH_ADDR;
        s_nxt.addressed = 1'b0;
        s_nxt.sda_drive = 1'b0;
        s_nxt.bits = 4'h0;
      end else begin
        case (s_r.phase)
          ICC_PH_ADDR, ICC_PH_ADDR2, ICC_PH_RX: begin
            if (scl_rise && s_r.bits != ICC_BYTE_BITS) begin
              s_nxt.shift = {s_r.shift[6:0], s_r.sy2.sda};
              s_nxt.bits = s_r.bits + 4'h1;
            end else if (scl_fall && s_r.bits == ICC_BYTE_BITS) begin
              s_nxt.phase = ICC_PH_ACK_OUT;
              s_nxt.after_ack = ICC_PH_RX;
              if (s_r.phase == ICC_PH_ADDR) begin
                if (s_r.ctrl[ICC_B_ACCEPT_ALL]) begin
                  hit = 1'b1;
                  to_tx = b[0];
                end else if (s_r.ctrl[ICC_B_TEN_BIT]) begin
                  // First byte of a 10-bit address carries the top two bits.
                  if (b[7:3] == ICC_TEN_PREFIX && b[2:1] == s_r.own[9:8]) begin
                    if (!b[0]) begin
                      s_nxt.after_ack = ICC_PH_ADDR2;
                      s_nxt.sda_drive = 1'b1;
                    end else if (s_r.ten_hit) begin
                      hit = 1'b1;
                      to_tx = 1'b1;
                    end
                  end
                end else if (b[7:1] == s_r.own[6:0]) begin
                  hit = 1'b1;
                  to_tx = b[0];
                end
                if (!hit && s_nxt.after_ack != ICC_PH_ADDR2) begin
                  s_nxt.phase = ICC_PH_SKIP;
                end
              end else if (s_r.phase == ICC_PH_ADDR2) begin
                if (b == s_r.own[7:0]) begin
                  hit = 1'b1;
                  s_nxt.ten_hit = 1'b1;
                end else begin
                  s_nxt.phase = ICC_PH_SKIP;
                end
              end else begin
                s_nxt.rx_byte = b;
                s_nxt.rx_full = 1'b1;
                s_nxt.sda_drive = 1'b1;
                if (stretch_enable) begin
                  s_nxt.ctrl[ICC_B_CLOCK_RELEASE] = 1'b0;
                end
              end
              if (hit) begin
                s_nxt.addressed = 1'b1;
                s_nxt.read_dir = to_tx;
                s_nxt.sda_drive = 1'b1;
                s_nxt.after_ack = to_tx ? ICC_PH_TX : ICC_PH_RX;
                s_nxt.ctrl[ICC_B_CLOCK_RELEASE] = 1'b0;
              end
            end
          end
          ICC_PH_ACK_OUT: begin
            if (scl_fall) begin
              s_nxt.phase = s_r.after_ack;
              s_nxt.bits = 4'h0;
              s_nxt.sda_drive = 1'b0;
              if (s_r.after_ack == ICC_PH_TX) begin
                s_nxt.shift = s_r.tx_byte;
                s_nxt.sda_drive = !s_r.tx_byte[7];
                s_nxt.ctrl[ICC_B_CLOCK_RELEASE] = 1'b0;
              end
            end
          end
          ICC_PH_TX: begin
            if (scl_rise) begin
              s_nxt.bits = s_r.bits + 4'h1;
            end else if (scl_fall && s_r.bits == ICC_BYTE_BITS) begin
              s_nxt.phase = ICC_PH_ACK_IN;
              s_nxt.sda_drive = 1'b0;
            end else if (scl_fall) begin
              s_nxt.shift = {s_r.shift[6:0], 1'b0};
              s_nxt.sda_drive = !s_r.shift[6];
            end
          end
          ICC_PH_ACK_IN: begin
            if (scl_rise) begin
              s_nxt.host_nack = s_r.sy2.sda;
            end else if (scl_fall) begin
              s_nxt.bits = 4'h0;
              if (!s_r.host_nack) begin
                s_nxt.phase = ICC_PH_TX;
                s_nxt.shift = s_r.tx_byte;
                s_nxt.sda_drive = !s_r.tx_byte[7];
                s_nxt.ctrl[ICC_B_CLOCK_RELEASE] = 1'b0;
              end else begin
                s_nxt.phase = ICC_PH_SKIP;
                s_nxt.addressed = 1'b0;
              end
            end
          end
          ICC_PH_SKIP, ICC_PH_IDLE: begin
            s_nxt.sda_drive = 1'b0;
          end
          default: begin
            s_nxt.phase = ICC_PH_IDLE;
          end
        endcase
      end
    end

    // Data byte read empties the receive holding register; a new byte arriving while it is empty wins.
    if (rd_data && !(s_nxt.rx_full && !s_r.rx_full)) begin
      s_nxt.rx_full = 1'b0;
    end

    // Software writes follow the engine so a write in the same cycle wins.
    if (wr_acc) begin
      case (paddr)
        ICC_OFS_CTRL: begin
          ctrl_wr = merge16(s_r.ctrl, pwdata[15:0], pstrb[1:0]) & ICC_CTRL_MASK;
          if (!stretch_enable) begin
            // Only a 1 may be written to the release bit here.
            ctrl_wr[ICC_B_CLOCK_RELEASE] = s_nxt.ctrl[ICC_B_CLOCK_RELEASE] |
                                           ctrl_wr[ICC_B_CLOCK_RELEASE];
          end
          s_nxt.ctrl = ctrl_wr;
        end
        ICC_OFS_OWN: begin
          own_wr = merge16({6'h00, s_r.own}, pwdata[15:0], pstrb[1:0]);
          s_nxt.own = own_wr[9:0];
        end
        ICC_OFS_DATA: begin
          if (pstrb[0]) begin
            s_nxt.tx_byte = pwdata[7:0];
          end
        end
        default: begin
          s_nxt.tx_byte = s_r.tx_byte;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{ctrl: ICC_CTRL_RESET, own: ICC_OWN_RESET, tx_byte: 8'h00, rx_byte: 8'h00,
               shift: 8'h00, bits: 4'h0, phase: ICC_PH_IDLE, after_ack: ICC_PH_IDLE,
               sy1: 2'b11, sy2: 2'b11, prev: 2'b11, addressed: 1'b0, read_dir: 1'b0,
               ten_hit: 1'b0, host_nack: 1'b0, rx_full: 1'b0, sda_drive: 1'b0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: src/icc_pkg.sv */
`default_nettype none
package icc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ICC_OFS_CTRL = 12'h000;
  localparam logic [11:0] ICC_OFS_OWN = 12'h004;
  localparam logic [11:0] ICC_OFS_STAT = 12'h008;
  localparam logic [11:0] ICC_OFS_DATA = 12'h00C;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned ICC_B_PORT_ENABLE = 15;
  localparam int unsigned ICC_B_HALT_IN_IDLE = 13;
  localparam int unsigned ICC_B_CLOCK_RELEASE = 12;
  localparam int unsigned ICC_B_ACCEPT_ALL = 11;
  localparam int unsigned ICC_B_TEN_BIT = 10;
  localparam int unsigned ICC_B_SLEW_OFF = 9;
  localparam int unsigned ICC_B_SMBUS = 8;
  localparam int unsigned ICC_B_STRETCH_EN = 6;
  localparam logic [15:0] ICC_CTRL_MASK = 16'hBF40;
  localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
  localparam logic [9:0] ICC_OWN_RESET = 10'h000;

  // ---------------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------------
  localparam int unsigned ICC_S_RX_FULL = 0;
  localparam int unsigned ICC_S_ADDRESSED = 1;
  localparam int unsigned ICC_S_READ_DIR = 2;
  localparam int unsigned ICC_S_TEN_HIT = 3;
  localparam int unsigned ICC_S_CLK_HELD = 4;

  // ---------------------------------------------------------------------------
  // Serial bus constants
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ICC_TEN_PREFIX = 5'h1E;
  localparam logic [3:0] ICC_BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    ICC_PH_IDLE = 3'b000,
    ICC_PH_ADDR = 3'b001,
    ICC_PH_ADDR2 = 3'b010,
    ICC_PH_RX = 3'b011,
    ICC_PH_TX = 3'b100,
    ICC_PH_ACK_OUT = 3'b101,
    ICC_PH_ACK_IN = 3'b110,
    ICC_PH_SKIP = 3'b111
  } icc_phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } icc_line_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [9:0] own;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] shift;
    logic [3:0] bits;
    icc_phase_t phase;
    icc_phase_t after_ack;
    icc_line_t sy1;
    icc_line_t sy2;
    icc_line_t prev;
    logic addressed;
    logic read_dir;
    logic ten_hit;
    logic host_nack;
    logic rx_full;
    logic sda_drive;
  } icc_state_t;

endpackage
`default_nettype wire

/* File: tb/icc_chk.sv */
`default_nettype none
module icc_chk
  import icc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic cpu_idle,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic pins_owned,
  input wire logic slew_control_off,
  input wire logic smbus_threshold_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_c;
  logic halt_r;
  assign wr_c = psel && penable && pwrite && pready && paddr == ICC_OFS_CTRL;
  // -------------------------------------------------------------------------
  // Shadow of the halt bit, taken from completed control writes.
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r <= 1'b0;
    end else if (wr_c) begin
      halt_r <= pwdata[13];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence halted_s;
    (halt_r && cpu_idle && pins_owned) [*2];
  endsequence
  sequence held_s;
    scl_oe && !wr_c && !cpu_idle;
  endsequence
  a_pins_follow: assert property (wr_c |=> pins_owned == $past(pwdata[15]))
    else $error("pin takeover does not follow the enable bit");
  a_slew_follow: assert property (wr_c |=> slew_control_off == $past(pwdata[9]))
    else $error("slew output does not follow its bit");
  a_level_follow: assert property (wr_c |=> smbus_threshold_select == $past(pwdata[8]))
    else $error("threshold output does not follow its bit");
  a_off_no_drive: assert property (!pins_owned |-> !scl_oe && !sda_oe)
    else $error("pins driven while disabled");
  a_halt_no_drive: assert property (halted_s |-> !scl_oe && !sda_oe)
    else $error("pins driven while halted in idle");
  a_release_frees: assert property (wr_c && pwdata[12] |=> !scl_oe)
    else $error("clock still held after release");
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch began with clock high");
  a_stretch_holds: assert property (held_s |=> scl_oe)
    else $error("stretch ended without release");
  a_unused_zero: assert property (psel && penable && !pwrite && paddr == ICC_OFS_CTRL
    |-> (prdata & ~32'h0000BF40) == 32'h0)
    else $error("unused control bits read nonzero");
endmodule
`default_nettype wire

/* File: tb/icc_host_model.sv */
`default_nettype none
module icc_host_model (
  output logic scl_pull,
  output logic sda_pull,
  input wire logic pclk,
  input wire logic scl_w,
  input wire logic sda_w
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic half();
    repeat (12) @(posedge pclk);
  endtask
  // Frees SCL and waits while a client stretches it; SCL stands still between frames.
  task automatic rise();
    int n;
    n = 0;
    scl_pull <= 1'b0;
    @(posedge pclk);
    while (!scl_w && n < 4000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic clk_bit(input logic b, output logic s);
    @(posedge pclk);
    sda_pull <= !b;
    half();
    rise();
    repeat (6) @(posedge pclk);
    s = sda_w;
    repeat (6) @(posedge pclk);
    scl_pull <= 1'b1;
  endtask
  task automatic start();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
  endtask
  task automatic stop();
    @(posedge pclk);
    sda_pull <= 1'b1;
    half();
    rise();
    half();
    sda_pull <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic hk, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(hk, ack);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_i2c_control_config.sv */
`default_nettype none
module test_i2c_control_config
  import icc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpu_idle = 1'b0, rerr, scl_pull, sda_pull, scl_oe, sda_oe, pready, pslverr;
  logic pins_owned, slew_control_off, smbus_threshold_select;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ctrl_v;
  int fails = 0, tests_run = 0;
  wire scl_w = !(scl_pull || scl_oe);
  wire sda_w = !(sda_pull || sda_oe);
  always #2.5 pclk = ~pclk;
  icc_control i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
    .pins_owned(pins_owned), .slew_control_off(slew_control_off),
    .smbus_threshold_select(smbus_threshold_select));
  icc_host_model i_host (.pclk(pclk), .scl_w(scl_w), .sda_w(sda_w), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wrd(input logic [31:0] d, input logic [31:0] exp);
    apb(1'b1, ICC_OFS_CTRL, d);
    apb(1'b0, ICC_OFS_CTRL, 32'h0);
    check(rd, exp);
  endtask
  // One byte on the bus; a stretch seen meanwhile is checked and released by software.
  task automatic byte_rel(input logic [7:0] tx, input int xst, output logic [7:0] rx,
                          output logic ack);
    logic done;
    int st;
    done = 1'b0;
    st = 0;
    fork
      begin
        i_host.xfer(tx, 1'b1, rx, ack);
        done = 1'b1;
      end
      while (!done) begin
        @(posedge pclk);
        if (scl_oe === 1'b1) begin
          st = 1;
          apb(1'b0, ICC_OFS_CTRL, 32'h0);
          check(rd, ctrl_v & 32'h0000AF40);
          apb(1'b1, ICC_OFS_CTRL, ctrl_v | 32'h1000);
        end
      end
    join
    if (xst != 2) check(st, xst);
  endtask
  task automatic setup(input logic [9:0] own, input logic [31:0] c);
    apb(1'b1, ICC_OFS_OWN, {22'h0, own});
    ctrl_v = c;
    apb(1'b1, ICC_OFS_CTRL, c);
  endtask
  task automatic t_regs();
    apb(1'b0, ICC_OFS_OWN, 32'h0);
    check(rd, 32'h0);
    wrd(32'h0, 32'h0);
    check({pins_owned, scl_oe, slew_control_off}, 32'h0);
    wrd(32'hFFFFFFFF, 32'h0000BF40);
    check({pins_owned, slew_control_off, smbus_threshold_select}, 32'h7);
    wrd(32'h8000, 32'h8000);
    wrd(32'h9000, 32'h9000);
    wrd(32'h8000, 32'h9000);
    apb(1'b1, ICC_OFS_CTRL, 32'h0);
    check({pins_owned, slew_control_off, smbus_threshold_select}, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    check({31'h0, rerr}, 32'h1);
  endtask
  task automatic bcase(input logic [9:0] own, input logic [31:0] c, input logic idle,
                       input logic [7:0] a, input logic exp);
    logic [7:0] rx;
    logic ack;
    setup(own, c);
    cpu_idle <= idle;
    i_host.start();
    byte_rel(a, 2, rx, ack);
    check(ack, exp);
    i_host.stop();
    cpu_idle <= 1'b0;
  endtask
  task automatic t_ten();
    logic [7:0] rx;
    logic ack;
    setup(10'h2A5, 32'h9400);
    for (int i = 0; i < 2; i++) begin
      i_host.start();
      byte_rel(8'hF4, 2, rx, ack);
      check(ack, 32'h0);
      byte_rel(8'hA4 + i[7:0], 2, rx, ack);
      check(ack, {31'h0, i == 0});
      i_host.stop();
    end
  endtask
  task automatic t_write(input logic [31:0] c, input int dst);
    logic [7:0] rx;
    logic ack;
    setup(10'h02A, c);
    i_host.start();
    byte_rel(8'h54, 1, rx, ack);
    check(ack, 32'h0);
    byte_rel(8'h5A, dst, rx, ack);
    check(ack, 32'h0);
    i_host.stop();
    apb(1'b0, ICC_OFS_DATA, 32'h0);
    check(rd, 32'h5A);
  endtask
  task automatic t_read(input logic [31:0] c);
    logic [7:0] rx;
    logic ack;
    setup(10'h02A, c);
    apb(1'b1, ICC_OFS_DATA, 32'h3C);
    i_host.start();
    byte_rel(8'h55, 1, rx, ack);
    check(ack, 32'h0);
    byte_rel(8'hFF, 1, rx, ack);
    check(rx, 32'h3C);
    i_host.stop();
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    $display("register test done");
    bcase(10'h02A, 32'h9000, 1'b0, 8'h54, 1'b0);
    bcase(10'h02A, 32'h9000, 1'b0, 8'h56, 1'b1);
    bcase(10'h02A, 32'h9800, 1'b0, 8'h56, 1'b0);
    bcase(10'h02A, 32'hB000, 1'b1, 8'h54, 1'b1);
    bcase(10'h02A, 32'hB000, 1'b0, 8'h54, 1'b0);
    bcase(10'h02A, 32'h9000, 1'b1, 8'h54, 1'b0);
    bcase(10'h02A, 32'h1000, 1'b0, 8'h54, 1'b1);
    bcase(10'h2A5, 32'h9000, 1'b0, 8'h4A, 1'b0);
    $display("address test done");
    t_ten();
    $display("ten bit test done");
    t_write(32'h8040, 1);
    t_write(32'h9000, 0);
    $display("write test done");
    t_read(32'h9040);
    t_read(32'h9000);
    $display("read test done");
    give_verdict();
  end
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule
bind icc_control icc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .cpu_idle(cpu_idle), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .pins_owned(pins_owned), .slew_control_off(slew_control_off),
  .smbus_threshold_select(smbus_threshold_select));
`default_nettype wire
